// file: logic/clkbuf_ctrl_pkg.sv
// shared constants and carriers of the clock buffer serial control slave
package clkbuf_ctrl_pkg;
  // bus framing
  localparam logic [7:0] WRITE_ADDR = 8'hD4;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  // control byte file
  localparam int NUM_BYTES = 7;
  localparam logic [2:0] LAST_INDEX = 3'h6;
  localparam logic [2:0] DISCARD_INDEX = 3'h7;
  localparam logic [2:0] FIRST_INDEX = 3'h0;
  localparam logic [7:0] POWER_UP_DEFAULT = 8'hFF;
  localparam logic [5:0] PAIRS_ON = 6'h3F;
  localparam int BYTE_A = 5;
  localparam int BYTE_B = 6;
  // enable bit positions for output pairs 0..5
  localparam int PAIR0_BIT = 7;
  localparam int PAIR1_BIT = 6;
  localparam int PAIR2_BIT = 3;
  localparam int PAIR3_BIT = 2;
  localparam int PAIR4_BIT = 3;
  localparam int PAIR5_BIT = 1;

  // position of a byte within one write frame
  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_CMD = 2'b01,
    PH_COUNT = 2'b10,
    PH_DATA = 2'b11
  } frame_phase_t;

  // one received data byte with its index
  typedef struct packed {
    logic [2:0] idx;
    logic [7:0] data;
  } data_word_t;

  typedef logic [NUM_BYTES-1:0][7:0] byte_file_t;
endpackage

// file: logic/clkbuf_ctrl_slave.sv
// serial block-write control slave driving the output pair enables
// What this block does
// - address D4 is acknowledged by device
// - command byte acknowledged, value ignored
// - byte count acknowledged before data
// - each data byte gets its own acknowledge
// - command and count discarded; first seven data bytes loaded, later ones discarded
// - byte 5 bits 7,6,3,2 enable pairs 0-3
// - byte 6 bits 3,1 enable pairs 4,5
// - bytes 0-4 reserved, all bits one until written
`timescale 1ns/1ps
`default_nettype none
module clkbuf_ctrl_slave (
  // system clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // two-wire bus, scl is the link clock
  input wire logic scl,
  input wire logic serial_bus_data_pin_in,
  output logic serial_bus_data_pin_out,
  output logic serial_bus_data_pin_oe,
  // control outputs and status
  output logic [5:0] pair_enable,
  output logic config_written,
  output logic bus_busy
);

  // state sampled on scl rising edges
  typedef struct packed {
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    clkbuf_ctrl_pkg::frame_phase_t phase;
    logic [2:0] data_idx;
    logic matched;
  } link_rise_t;

  // state updated on scl falling edges
  typedef struct packed {
    logic ack_oe;
    logic tog;
    clkbuf_ctrl_pkg::data_word_t word;
  } link_fall_t;

  // system clock state
  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    logic tog_m;
    logic tog_s;
    logic tog_d;
    logic arm;
    logic link_run;
    logic written;
    logic [5:0] pair;
    clkbuf_ctrl_pkg::byte_file_t cfg;
  } core_t;

  link_rise_t rise;
  link_rise_t next_rise;
  link_fall_t fall;
  link_fall_t next_fall;
  core_t core;
  core_t next_core;
  logic link_rst_b;
  logic start_seen;
  logic stop_seen;
  logic word_seen;

  // acknowledge decision for the byte just shifted in
  // later bytes follow the match
  function automatic logic accept_byte(input clkbuf_ctrl_pkg::frame_phase_t ph,
                                       input logic [7:0] b, input logic m);
    accept_byte = (ph == clkbuf_ctrl_pkg::PH_ADDR) ? (b == clkbuf_ctrl_pkg::WRITE_ADDR) : m;
  endfunction

  // map the two control bytes onto the six pair enables
  // pair enable bits
  function automatic logic [5:0] pair_map(input clkbuf_ctrl_pkg::byte_file_t f);
    pair_map = {f[clkbuf_ctrl_pkg::BYTE_B][clkbuf_ctrl_pkg::PAIR5_BIT],
                f[clkbuf_ctrl_pkg::BYTE_B][clkbuf_ctrl_pkg::PAIR4_BIT],
                f[clkbuf_ctrl_pkg::BYTE_A][clkbuf_ctrl_pkg::PAIR3_BIT],
                f[clkbuf_ctrl_pkg::BYTE_A][clkbuf_ctrl_pkg::PAIR2_BIT],
                f[clkbuf_ctrl_pkg::BYTE_A][clkbuf_ctrl_pkg::PAIR1_BIT],
                f[clkbuf_ctrl_pkg::BYTE_A][clkbuf_ctrl_pkg::PAIR0_BIT]};
  endfunction

  // link logic is held in reset outside frames; release happens while scl is low
  assign link_rst_b = rst_b & core.link_run;

  // rising edge: shift bits, step the phase at the end of each ack slot
  always_comb begin
    next_rise = rise;
    if (rise.bit_cnt == clkbuf_ctrl_pkg::ACK_SLOT) begin
      next_rise.bit_cnt = clkbuf_ctrl_pkg::BIT_ZERO;
      if (rise.phase == clkbuf_ctrl_pkg::PH_ADDR) begin
        next_rise.matched = (rise.shift == clkbuf_ctrl_pkg::WRITE_ADDR);
      end
      unique case (rise.phase)
        clkbuf_ctrl_pkg::PH_ADDR: next_rise.phase = clkbuf_ctrl_pkg::PH_CMD;
        clkbuf_ctrl_pkg::PH_CMD: next_rise.phase = clkbuf_ctrl_pkg::PH_COUNT;
        clkbuf_ctrl_pkg::PH_COUNT: next_rise.phase = clkbuf_ctrl_pkg::PH_DATA;
        clkbuf_ctrl_pkg::PH_DATA: begin
          // sequential index, saturating at the discard slot
          if (rise.data_idx != clkbuf_ctrl_pkg::DISCARD_INDEX) begin
            next_rise.data_idx = rise.data_idx + 3'h1;
          end
        end
      endcase
    end else begin
      next_rise.shift = {rise.shift[6:0], serial_bus_data_pin_in};
      next_rise.bit_cnt = rise.bit_cnt + 4'h1;
    end
  end

  // rising edge registers
  always_ff @(posedge scl or negedge link_rst_b) begin
    if (!link_rst_b) begin
      rise <= '{bit_cnt: clkbuf_ctrl_pkg::BIT_ZERO, shift: 8'h00,
                phase: clkbuf_ctrl_pkg::PH_ADDR, data_idx: clkbuf_ctrl_pkg::FIRST_INDEX,
                matched: 1'b0};
    end else begin
      rise <= next_rise;
    end
  end

  // falling edge: drive the ack slot and hand data bytes over
  always_comb begin
    next_fall = fall;
    // one acknowledge per byte of a frame whose address matched, in the slot after it
    next_fall.ack_oe = (rise.bit_cnt == clkbuf_ctrl_pkg::BITS_PER_BYTE) &&
                       accept_byte(rise.phase, rise.shift, rise.matched);
    // only data bytes are published, command and count are dropped
    if ((rise.bit_cnt == clkbuf_ctrl_pkg::BITS_PER_BYTE) && rise.matched &&
        (rise.phase == clkbuf_ctrl_pkg::PH_DATA)) begin
      next_fall.word = '{idx: rise.data_idx, data: rise.shift};
      next_fall.tog = ~fall.tog;
    end
  end

  // falling edge registers; not reset per frame so the toggle never jumps
  always_ff @(negedge scl or negedge rst_b) begin
    if (!rst_b) begin
      fall <= '{ack_oe: 1'b0, tog: 1'b0, word: '{idx: clkbuf_ctrl_pkg::FIRST_INDEX, data: 8'h00}};
    end else begin
      fall <= next_fall;
    end
  end

  // bus condition detection on synchronised pins
  assign start_seen = core.scl_s && core.scl_d && core.sda_d && !core.sda_s;
  assign stop_seen = core.scl_s && core.scl_d && !core.sda_d && core.sda_s;
  assign word_seen = core.tog_s ^ core.tog_d;

  // system side: synchronisers, frame control, byte file
  always_comb begin
    next_core = core;
    next_core.scl_m = scl;
    next_core.scl_s = core.scl_m;
    next_core.scl_d = core.scl_s;
    next_core.sda_m = serial_bus_data_pin_in;
    next_core.sda_s = core.sda_m;
    next_core.sda_d = core.sda_s;
    next_core.tog_m = fall.tog;
    next_core.tog_s = core.tog_m;
    next_core.tog_d = core.tog_s;
    // a start reopens the frame once scl goes low
    if (start_seen) begin
      next_core.arm = 1'b1;
      next_core.link_run = 1'b0;
    end else if (stop_seen) begin
      next_core.arm = 1'b0;
      next_core.link_run = 1'b0;
    end else if (core.arm && !core.scl_s) begin
      next_core.arm = 1'b0;
      next_core.link_run = 1'b1;
    end
    // store the handed-over byte at its index
    if (word_seen && (fall.word.idx <= clkbuf_ctrl_pkg::LAST_INDEX)) begin
      next_core.cfg[fall.word.idx] = fall.word.data;
      next_core.written = 1'b1;
    end
    // pair enables follow the control bytes
    next_core.pair = pair_map(core.cfg);
  end

  // system registers; every byte powers up as all ones
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      core <= '{scl_m: 1'b1, scl_s: 1'b1, scl_d: 1'b1, sda_m: 1'b1, sda_s: 1'b1,
                sda_d: 1'b1, tog_m: 1'b0, tog_s: 1'b0, tog_d: 1'b0, arm: 1'b0,
                link_run: 1'b0, written: 1'b0, pair: clkbuf_ctrl_pkg::PAIRS_ON,
                cfg: {clkbuf_ctrl_pkg::NUM_BYTES{clkbuf_ctrl_pkg::POWER_UP_DEFAULT}}};
    end else begin
      core <= next_core;
    end
  end

  // outputs; the pin is only ever pulled low
  assign serial_bus_data_pin_out = 1'b0;
  assign serial_bus_data_pin_oe = fall.ack_oe & core.link_run;
  assign pair_enable = core.pair;
  assign config_written = core.written;
  assign bus_busy = core.link_run | core.arm;

  // address D4 is acknowledged
  a_addr_ack: assert property (@(posedge scl) disable iff (!link_rst_b)
    (rise.bit_cnt == clkbuf_ctrl_pkg::BITS_PER_BYTE &&
     rise.phase == clkbuf_ctrl_pkg::PH_ADDR &&
     rise.shift == clkbuf_ctrl_pkg::WRITE_ADDR) |-> serial_bus_data_pin_oe)
    else $error("address not acknowledged");

  // command byte acknowledged after a match
  a_cmd_ack: assert property (@(posedge scl) disable iff (!link_rst_b)
    (rise.bit_cnt == clkbuf_ctrl_pkg::BITS_PER_BYTE &&
     rise.phase == clkbuf_ctrl_pkg::PH_CMD && rise.matched)
    |-> serial_bus_data_pin_oe)
    else $error("command byte not acknowledged");

  // count byte acknowledged after a match
  a_count_ack: assert property (@(posedge scl) disable iff (!link_rst_b)
    (rise.bit_cnt == clkbuf_ctrl_pkg::BITS_PER_BYTE &&
     rise.phase == clkbuf_ctrl_pkg::PH_COUNT && rise.matched)
    |-> serial_bus_data_pin_oe)
    else $error("count byte not acknowledged");

  // every data byte acknowledged, and released one bit later
  a_data_ack: assert property (@(posedge scl) disable iff (!link_rst_b)
    (rise.bit_cnt == clkbuf_ctrl_pkg::BITS_PER_BYTE &&
     rise.phase == clkbuf_ctrl_pkg::PH_DATA && rise.matched)
    |-> serial_bus_data_pin_oe ##1 !serial_bus_data_pin_oe)
    else $error("data byte acknowledge wrong");

  // command and count never handed over
  a_no_dummy_pub: assert property (@(negedge scl) disable iff (!link_rst_b)
    (rise.bit_cnt == clkbuf_ctrl_pkg::BITS_PER_BYTE &&
     rise.phase != clkbuf_ctrl_pkg::PH_DATA) |=> $stable(fall.tog))
    else $error("dummy byte was published");

  // handed-over byte lands in the file
  a_data_store: assert property (@(posedge clk) disable iff (!rst_b)
    (word_seen && fall.word.idx <= clkbuf_ctrl_pkg::LAST_INDEX) |=>
    core.cfg[$past(fall.word.idx)] == $past(fall.word.data))
    else $error("data byte not stored");

  // pair enables track bytes 5 and 6
  a_pair_map: assert property (@(posedge clk) disable iff (!rst_b)
    ##1 pair_enable == {$past(core.cfg[6][1]), $past(core.cfg[6][3]),
                        $past(core.cfg[5][2]), $past(core.cfg[5][3]),
                        $past(core.cfg[5][6]), $past(core.cfg[5][7])})
    else $error("pair enable mapping wrong");

  // byte 6 bits zero disable pairs 4 and 5
  a_byte6_pairs: assert property (@(posedge clk) disable iff (!rst_b)
    (core.cfg[6][3] == 1'b0 && core.cfg[6][1] == 1'b0) |=> ##1
    (pair_enable[5:4] == 2'b00 || $past(core.cfg[6][3]) || $past(core.cfg[6][1])))
    else $error("pairs 4 and 5 not disabled");

  // untouched file reads all ones
  a_power_default: assert property (@(posedge clk) disable iff (!rst_b)
    !config_written |->
    (core.cfg == {clkbuf_ctrl_pkg::NUM_BYTES{clkbuf_ctrl_pkg::POWER_UP_DEFAULT}} &&
     pair_enable == clkbuf_ctrl_pkg::PAIRS_ON))
    else $error("power-up default lost");

endmodule
`default_nettype wire

// file: tb/host_bus_model.sv
// two-wire bus host model issuing block writes toward the slave
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  // bus lines
  output logic scl,
  output logic sda_host,
  input wire logic sda_wire,
  // ack report toward the bench monitor
  output logic ack_bit,
  output logic ack_strobe
);
  localparam int HALF = 24;

  // idle bus: clock stands high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_host = 1'b1;
    ack_bit = 1'b1;
    ack_strobe = 1'b0;
  end

  task automatic start();
    // odd offset keeps the start condition edges off the system clock edges
    #3;
    #(2*HALF) sda_host = 1'b0;
    #(2*HALF) scl = 1'b0;
    #(2*HALF);
  endtask

  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      #(HALF/2) sda_host = b[i];
      #(HALF/2) scl = 1'b1;
      #(HALF) scl = 1'b0;
    end
    // released data floats up unless the slave pulls it low
    #(HALF/2) sda_host = 1'b1;
    #(HALF/2) scl = 1'b1;
    #(HALF/2) ack_bit = sda_wire;
    ack_strobe = 1'b1;
    #(HALF/2) scl = 1'b0;
    ack_strobe = 1'b0;
  endtask

  task automatic stop();
    #(HALF/2) sda_host = 1'b0;
    #(HALF/2) scl = 1'b1;
    #(2*HALF) sda_host = 1'b1;
    #(4*HALF);
  endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
// self-checking bench of the serial block-write control slave
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, rst_b, scl, sda_host, sda_wire, dev_out, dev_oe;
  logic config_written, bus_busy, ack_bit, ack_strobe, cfg;
  logic [5:0] pair_enable;
  logic [31:0] lfsr;
  logic [7:0] dat [8];
  logic [7:0] ctrl5, ctrl6;
  logic ack_q [$];
  int nb [8] = '{7, 7, 7, 8, 6, 0, 7, 1};
  int fails;
  int comparisons;

  clkbuf_ctrl_slave clkbuf_ctrl_slave_i (.clk(clk), .rst_b(rst_b), .scl(scl),
    .serial_bus_data_pin_in(sda_wire), .serial_bus_data_pin_out(dev_out),
    .serial_bus_data_pin_oe(dev_oe), .pair_enable(pair_enable),
    .config_written(config_written), .bus_busy(bus_busy));
  host_bus_model host_bus_model_i (.scl(scl), .sda_host(sda_host),
    .sda_wire(sda_wire), .ack_bit(ack_bit), .ack_strobe(ack_strobe));

  // open drain wire with pull-up
  assign sda_wire = sda_host & ~(dev_oe & ~dev_out);

  // system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // each sampled ack is matched against the oldest note
  always @(posedge ack_strobe) begin
    if (ack_q.size() == 0) begin
      check("ack_spare", 8'h01, 8'h00);
    end else begin
      check("ack", {7'h00, ack_bit}, {7'h00, ack_q.pop_front()});
    end
  end

  // one block write: address, then command, count and n data bytes only if the address matches
  task automatic frame(input logic [7:0] addr, input int n);
    logic ok;
    logic [7:0] want;
    ok = (addr == clkbuf_ctrl_pkg::WRITE_ADDR);
    host_bus_model_i.start();
    ack_q.push_back(!ok);
    host_bus_model_i.send_byte(addr);
    check("bus_busy", {7'h00, bus_busy}, 8'h01);
    for (int i = -2; ok && i < n; i++) begin
      ack_q.push_back(1'b0);
      lfsr = lfsr_next(lfsr);
      host_bus_model_i.send_byte(i < 0 ? lfsr[15:8] : dat[i]);
    end
    host_bus_model_i.stop();
    if (ok && n > 5) ctrl5 = dat[5];
    if (ok && n > 6) ctrl6 = dat[6];
    if (ok && n > 0) cfg = 1'b1;
    want = {2'b00, ctrl6[1], ctrl6[3], ctrl5[2], ctrl5[3], ctrl5[6], ctrl5[7]};
    repeat (20) @(posedge clk);
    check("bus_busy", {7'h00, bus_busy}, 8'h00);
    check("config_written", {7'h00, config_written}, {7'h00, cfg});
    check("pair_enable", {2'b00, pair_enable}, want);
  endtask

  // main sequence: reset, then good, foreign and short writes
  initial begin
    rst_b = 1'b0;
    fails = 0;
    comparisons = 0;
    lfsr = 32'h00E8B532;
    ctrl5 = 8'hFF;
    ctrl6 = 8'hFF;
    cfg = 1'b0;
    repeat (6) @(posedge clk);
    check("pair_enable", {2'b00, pair_enable}, 8'h3F);
    check("sda_oe", {7'h00, dev_oe}, 8'h00);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    for (int k = 0; k < 8; k++) begin
      for (int j = 0; j < 8; j++) begin
        lfsr = lfsr_next(lfsr);
        dat[j] = lfsr[7:0];
      end
      // one write clears both pair 4 and pair 5
      if (k == 6) dat[6] = dat[6] & 8'hF5;
      frame(k == 1 ? 8'hD5 : (k == 2 ? 8'h54 : clkbuf_ctrl_pkg::WRITE_ADDR), nb[k]);
    end
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    check("config_written", {7'h00, config_written}, 8'h00);
    check("pair_enable", {2'b00, pair_enable}, 8'h3F);
    ctrl5 = 8'hFF;
    ctrl6 = 8'hFF;
    cfg = 1'b0;
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    frame(clkbuf_ctrl_pkg::WRITE_ADDR, 7);
    final_report();
  end

  // watchdog against a hung bus
  initial begin
    #200000;
    fails++;
    final_report();
  end
endmodule
`default_nettype wire
